// >>> src/srb_pkg.sv
/*
  Package for the shift, rotate and single-bit datapath: operation codes,
  operand sizes, request and result carriers, reset values.
  Assumes the decoder presents one decoded operation per request.
*/
// Functional notes
// - Arithmetic shifts left/right on byte, word or long register, result written back.
// - Logical shifts left/right on byte, word or long register, result written back.
// - Plain rotates left/right on byte, word or long register, result written back.
// - Rotate through carry: outgoing bit goes to carry, old carry enters register.
// - Bit set forces selected byte bit to one, others unchanged.
// - Bit clear forces selected byte bit to zero, others unchanged.
// - Bit invert complements only the selected bit and writes the byte back.
// - Bit test loads zero flag with inverse of selected bit, operand untouched.
// - Set, clear, invert, test take bit number from immediate or register low three bits.
// - Carry AND: carry becomes carry AND selected bit.
// - Inverted carry AND: carry becomes carry AND inverse of selected bit.
// - Carry OR: carry becomes carry OR selected bit.
// - Inverted carry OR: carry becomes carry OR inverse of selected bit.
// - Carry XOR: carry becomes carry XOR selected bit.
// - Inverted carry XOR: carry becomes carry XOR inverse of selected bit.
// - Bit load copies selected bit into carry, operand untouched.
// - Inverted bit load copies inverse of selected bit into carry.
// - Bit store writes carry into selected bit, others unchanged.
// - Inverted bit store writes inverse carry into selected bit.
// - Inverted carry logic, load and store take bit number from immediate only.
package srb_pkg;

  typedef enum logic [4:0] {
    OP_ARITH_SHIFT_LEFT   = 5'h00,
    OP_ARITH_SHIFT_RIGHT  = 5'h01,
    OP_LOGIC_SHIFT_LEFT   = 5'h02,
    OP_LOGIC_SHIFT_RIGHT  = 5'h03,
    OP_ROTATE_LEFT        = 5'h04,
    OP_ROTATE_RIGHT       = 5'h05,
    OP_ROTATE_CARRY_LEFT  = 5'h06,
    OP_ROTATE_CARRY_RIGHT = 5'h07,
    OP_BIT_SET            = 5'h08,
    OP_BIT_CLEAR          = 5'h09,
    OP_BIT_INVERT         = 5'h0a,
    OP_BIT_TEST           = 5'h0b,
    OP_CARRY_AND          = 5'h0c,
    OP_CARRY_AND_INV      = 5'h0d,
    OP_CARRY_OR           = 5'h0e,
    OP_CARRY_OR_INV       = 5'h0f,
    OP_CARRY_XOR          = 5'h10,
    OP_CARRY_XOR_INV      = 5'h11,
    OP_BIT_LOAD           = 5'h12,
    OP_BIT_LOAD_INV       = 5'h13,
    OP_BIT_STORE          = 5'h14,
    OP_BIT_STORE_INV      = 5'h15
  } srb_op_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } srb_size_e;

  // Sequencer states, Gray along idle -> read wait -> back to idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM_WAIT = 2'b01
  } srb_state_e;

  typedef struct packed {
    srb_op_e op;
    srb_size_e size;
    logic [31:0] regVal;
    logic [2:0] bitImm;
    logic bitFromReg;
    logic [2:0] bitRegLow;
    logic memOperand;
    logic carryIn;
    logic [31:0] memAddr;
  } srb_req_s;

  typedef struct packed {
    logic [31:0] value;
    logic regWrite;
    logic carry;
    logic carryWrite;
    logic zero;
    logic zeroWrite;
    logic badRequest;
  } srb_res_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] wdata;
    logic read;
    logic write;
  } srb_mem_s;

  localparam int unsigned SRB_WIDTH = 32;
  localparam int unsigned SRB_BIT_NO_W = 3;
  localparam logic [31:0] SRB_DATA_RST = 32'h0000_0000;
  localparam logic SRB_FLAG_RST = 1'b0;

endpackage

// >>> src/srb_shift_bit_unit.sv
/*
  Shift, rotate and single-bit execution unit of the core.
  Assumes: decoder holds reqValid one cycle per request while busy is low;
  memory answers a byte read with memRdValid one or more cycles after the
  read strobe; register file takes res when resValid is high.
*/
`timescale 1ns/100ps
module srb_shift_bit_unit (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reqValid,
  input srb_pkg::srb_req_s req,
  input wire logic memRdValid,
  input wire logic [7:0] memRdData,
  output srb_pkg::srb_res_s res,
  output logic resValid,
  output srb_pkg::srb_mem_s mem,
  output logic busy
);
  import srb_pkg::*;

  srb_state_e state_q;
  srb_req_s held_q;
  srb_res_s res_q;
  srb_mem_s mem_q;
  logic resValid_q;
  logic busy_q;
  srb_res_s calc;
  srb_req_s curReq;
  logic [7:0] byteIn;

  // Bit operations must not take a register bit number when the op is inverted
  function automatic logic invOp(input srb_op_e o);
    invOp = (o == OP_CARRY_AND_INV) || (o == OP_CARRY_OR_INV) || (o == OP_CARRY_XOR_INV) ||
            (o == OP_BIT_LOAD_INV) || (o == OP_BIT_STORE_INV);
  endfunction

  function automatic logic setLike(input srb_op_e o);
    setLike = (o == OP_BIT_SET) || (o == OP_BIT_CLEAR) || (o == OP_BIT_INVERT) ||
              (o == OP_BIT_TEST);
  endfunction

  function automatic logic modOp(input srb_op_e o);
    modOp = (o == OP_BIT_SET) || (o == OP_BIT_CLEAR) || (o == OP_BIT_INVERT) ||
            (o == OP_BIT_STORE) || (o == OP_BIT_STORE_INV);
  endfunction

  assign curReq = (state_q == ST_MEM_WAIT) ? held_q : req;
  assign byteIn = (state_q == ST_MEM_WAIT) ? memRdData : req.regVal[7:0];

  always_comb begin
    logic [2:0] bitNo;
    logic sel;
    logic msb;
    logic lsb;
    logic [31:0] v;
    logic [31:0] r;
    logic co;
    bitNo = '0;
    sel = 1'b0;
    msb = 1'b0;
    lsb = 1'b0;
    v = curReq.regVal;
    r = v;
    co = 1'b0;
    calc = '0;
    calc.value = v;
    calc.carry = curReq.carryIn;
    // Register bit number only for set, clear, invert, test
    bitNo = (curReq.bitFromReg && setLike(curReq.op)) ? curReq.bitRegLow : curReq.bitImm;
    calc.badRequest = curReq.bitFromReg && invOp(curReq.op);
    sel = byteIn[bitNo];
    case (curReq.size)
      SZ_BYTE: begin
        msb = v[7];
      end
      SZ_WORD: begin
        msb = v[15];
      end
      default: begin
        msb = v[31];
      end
    endcase
    lsb = v[0];
    case (curReq.op)
      OP_ARITH_SHIFT_LEFT, OP_LOGIC_SHIFT_LEFT: begin
        r = {v[30:0], 1'b0};
        co = msb;
      end
      OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_RIGHT: begin
        r = {1'b0, v[31:1]};
        co = lsb;
        if (curReq.op == OP_ARITH_SHIFT_RIGHT) begin
          case (curReq.size)
            SZ_BYTE: r[7] = msb;
            SZ_WORD: r[15] = msb;
            default: r[31] = msb;
          endcase
        end else begin
          case (curReq.size)
            SZ_BYTE: r[7] = 1'b0;
            SZ_WORD: r[15] = 1'b0;
            default: r[31] = 1'b0;
          endcase
        end
      end
      OP_ROTATE_LEFT, OP_ROTATE_CARRY_LEFT: begin
        r = {v[30:0], (curReq.op == OP_ROTATE_LEFT) ? msb : curReq.carryIn};
        co = msb;
      end
      OP_ROTATE_RIGHT, OP_ROTATE_CARRY_RIGHT: begin
        r = {1'b0, v[31:1]};
        co = lsb;
        case (curReq.size)
          SZ_BYTE: r[7] = (curReq.op == OP_ROTATE_RIGHT) ? lsb : curReq.carryIn;
          SZ_WORD: r[15] = (curReq.op == OP_ROTATE_RIGHT) ? lsb : curReq.carryIn;
          default: r[31] = (curReq.op == OP_ROTATE_RIGHT) ? lsb : curReq.carryIn;
        endcase
      end
      default: begin
        r = v;
      end
    endcase
    if (curReq.op <= OP_ROTATE_CARRY_RIGHT) begin
      // Keep bits above the operand size untouched
      case (curReq.size)
        SZ_BYTE: calc.value = {v[31:8], r[7:0]};
        SZ_WORD: calc.value = {v[31:16], r[15:0]};
        default: calc.value = r;
      endcase
      calc.regWrite = 1'b1;
      calc.carry = co;
      calc.carryWrite = 1'b1;
    end else begin
      calc.value = {24'h000000, byteIn};
      case (curReq.op)
        OP_BIT_SET: calc.value[bitNo] = 1'b1;
        OP_BIT_CLEAR: calc.value[bitNo] = 1'b0;
        OP_BIT_INVERT: calc.value[bitNo] = ~sel;
        OP_BIT_TEST: begin
          calc.zero = ~sel;
          calc.zeroWrite = 1'b1;
        end
        OP_CARRY_AND: calc.carry = curReq.carryIn & sel;
        OP_CARRY_AND_INV: calc.carry = curReq.carryIn & ~sel;
        OP_CARRY_OR: calc.carry = curReq.carryIn | sel;
        OP_CARRY_OR_INV: calc.carry = curReq.carryIn | ~sel;
        OP_CARRY_XOR: calc.carry = curReq.carryIn ^ sel;
        OP_CARRY_XOR_INV: calc.carry = curReq.carryIn ^ ~sel;
        OP_BIT_LOAD: calc.carry = sel;
        OP_BIT_LOAD_INV: calc.carry = ~sel;
        OP_BIT_STORE: calc.value[bitNo] = curReq.carryIn;
        OP_BIT_STORE_INV: calc.value[bitNo] = ~curReq.carryIn;
        default: calc.value = {24'h000000, byteIn};
      endcase
      calc.carryWrite = (curReq.op >= OP_CARRY_AND) && (curReq.op <= OP_BIT_LOAD_INV);
      calc.regWrite = modOp(curReq.op) && !curReq.memOperand;
      if (!curReq.memOperand) begin
        calc.value = {v[31:8], calc.value[7:0]};
      end
      if (calc.badRequest) begin
        calc.carryWrite = 1'b0;
        calc.regWrite = 1'b0;
        calc.zeroWrite = 1'b0;
      end
    end
  end

  // Sequencer: memory bit operations read the byte first
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      held_q <= '0;
      busy_q <= SRB_FLAG_RST;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (reqValid && req.op >= OP_BIT_SET && req.memOperand) begin
            state_q <= ST_MEM_WAIT;
            held_q <= req;
            busy_q <= 1'b1;
          end
        end
        ST_MEM_WAIT: begin
          if (memRdValid) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  logic finish;
  assign finish = (state_q == ST_IDLE) ? (reqValid && !(req.op >= OP_BIT_SET && req.memOperand))
                                       : memRdValid;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      res_q <= '0;
      resValid_q <= 1'b0;
    end else begin
      resValid_q <= finish;
      if (finish) begin
        res_q <= calc;
      end
    end
  end

  // Memory strobes: byte read, then whole-byte write-back for modifying ops
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mem_q <= '0;
    end else begin
      mem_q.read <= (state_q == ST_IDLE) && reqValid && req.op >= OP_BIT_SET && req.memOperand;
      mem_q.write <= (state_q == ST_MEM_WAIT) && memRdValid && modOp(held_q.op) &&
                     !calc.badRequest;
      if (state_q == ST_IDLE && reqValid) begin
        mem_q.addr <= req.memAddr;
      end
      if (state_q == ST_MEM_WAIT && memRdValid) begin
        mem_q.wdata <= calc.value[7:0];
      end
    end
  end

  assign res = res_q;
  assign resValid = resValid_q;
  assign mem = mem_q;
  assign busy = busy_q;

  AST_SET_REG: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_BIT_SET && !req.memOperand && !req.bitFromReg)
    |=> resValid && res.value[$past(req.bitImm)] == 1'b1 && res.regWrite)
    else $error("bit set did not set bit");
  AST_TEST_NOWR: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_BIT_TEST && !req.memOperand)
    |=> resValid && !res.regWrite && res.zeroWrite)
    else $error("bit test modified operand");
  AST_LOAD: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_BIT_LOAD && !req.memOperand && !req.bitFromReg)
    |=> res.carry == $past(req.regVal[req.bitImm]))
    else $error("bit load carry wrong");
  AST_INV_REG: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_BIT_LOAD_INV && req.bitFromReg && !req.memOperand)
    |=> res.badRequest && !res.carryWrite)
    else $error("inverted op accepted register bit number");
  AST_SHL_CARRY: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_LOGIC_SHIFT_LEFT && req.size == SZ_BYTE)
    |=> res.carry == $past(req.regVal[7]) && res.value[0] == 1'b0)
    else $error("shift left carry wrong");
  AST_SAR: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_ARITH_SHIFT_RIGHT && req.size == SZ_LONG)
    |=> res.value[31] == $past(req.regVal[31]) && res.value[30] == $past(req.regVal[31]))
    else $error("arith shift right lost sign");
  AST_ROTC: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_ROTATE_CARRY_LEFT)
    |=> res.value[0] == $past(req.carryIn))
    else $error("rotate through carry lost carry");
  sequence memReadSeq;
    mem.read ##[1:64] memRdValid;
  endsequence
  AST_RMW: assert property (@(posedge mclk) disable iff (!nrst)
    (busy && memRdValid && held_q.op == OP_BIT_SET && !held_q.bitFromReg)
    |=> mem.write && mem.wdata[$past(held_q.bitImm)] == 1'b1)
    else $error("memory write-back missing");
  AST_RD: cover property (@(posedge mclk) memReadSeq);
  sequence memReqSeq;
    reqValid && !busy && req.op >= OP_BIT_SET && req.memOperand;
  endsequence
  AST_MEM_READ: assert property (@(posedge mclk) disable iff (!nrst)
    memReqSeq |=> mem.read && busy && !resValid)
    else $error("memory bit op did not start a byte read");
  AST_CLR_REG: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_BIT_CLEAR && !req.memOperand && !req.bitFromReg)
    |=> resValid && res.value[$past(req.bitImm)] == 1'b0 && res.regWrite)
    else $error("bit clear did not clear bit");
  AST_INV_BIT: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_BIT_INVERT && !req.memOperand && !req.bitFromReg)
    |=> res.value[$past(req.bitImm)] == ~$past(req.regVal[req.bitImm]))
    else $error("bit invert wrong");
  AST_REG_BITNO: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_BIT_SET && !req.memOperand && req.bitFromReg)
    |=> res.value[$past(req.bitRegLow)] == 1'b1 && !res.badRequest)
    else $error("register bit number not used");
  AST_CAND: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_CARRY_AND && !req.memOperand && !req.bitFromReg)
    |=> res.carryWrite && res.carry == ($past(req.carryIn) & $past(req.regVal[req.bitImm])))
    else $error("carry and wrong");
  AST_COR_INV: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_CARRY_OR_INV && !req.memOperand && !req.bitFromReg)
    |=> res.carryWrite && res.carry == ($past(req.carryIn) | ~$past(req.regVal[req.bitImm])))
    else $error("inverted carry or wrong");
  AST_CXOR_INV: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_CARRY_XOR_INV && !req.memOperand && !req.bitFromReg)
    |=> res.carryWrite && res.carry == ($past(req.carryIn) ^ ~$past(req.regVal[req.bitImm])))
    else $error("inverted carry xor wrong");
  AST_STORE: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_BIT_STORE && !req.memOperand && !req.bitFromReg)
    |=> res.regWrite && res.value[$past(req.bitImm)] == $past(req.carryIn))
    else $error("bit store wrong");
  AST_STORE_INV: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_BIT_STORE_INV && !req.memOperand && !req.bitFromReg)
    |=> res.regWrite && res.value[$past(req.bitImm)] == ~$past(req.carryIn))
    else $error("inverted bit store wrong");
  AST_LSR: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_LOGIC_SHIFT_RIGHT && req.size == SZ_WORD)
    |=> res.value[15] == 1'b0 && res.value[31:16] == $past(req.regVal[31:16]) &&
        res.carry == $past(req.regVal[0]))
    else $error("logical shift right wrong");
  AST_ROR: assert property (@(posedge mclk) disable iff (!nrst)
    (reqValid && !busy && req.op == OP_ROTATE_RIGHT && req.size == SZ_BYTE)
    |=> res.value[7] == $past(req.regVal[0]) && res.value[6] == $past(req.regVal[7]))
    else $error("rotate right wrong");

endmodule // srb_shift_bit_unit

// >>> tb/srb_mem_model.sv
/*
  Byte memory seen by the unit: answers reads after a set latency, takes writes.
  Assumes one read outstanding at a time and a latency of at least one cycle.
*/
`timescale 1ns/100ps
module srb_mem_model (
  input wire logic mclk,
  input wire logic nrst,
  input srb_pkg::srb_mem_s mem,
  input wire logic [3:0] lat,
  output logic memRdValid,
  output logic [7:0] memRdData
);
  import srb_pkg::*;
  logic [7:0] store [16];
  logic [3:0] cnt_q;
  logic [3:0] addr_q;
  initial begin
    for (int i = 0; i < 16; i++) begin
      store[i] = 8'h3c ^ 8'(i * 8'h55);
    end
  end
  // Outside a valid cycle the data bus toggles so a stale byte is never trusted
  always @(posedge mclk) begin
    memRdValid <= 1'b0;
    memRdData <= ~memRdData;
    if (!nrst) begin
      cnt_q <= 4'h0;
      memRdData <= 8'h5a;
    end else if (mem.read) begin
      cnt_q <= lat;
      addr_q <= mem.addr[3:0];
    end else if (cnt_q == 4'h1) begin
      memRdValid <= 1'b1;
      memRdData <= store[addr_q];
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
    if (mem.write) begin
      store[mem.addr[3:0]] <= mem.wdata;
    end
  end
endmodule // srb_mem_model

// >>> tb/srb_shift_bit_unit_tb.sv
/*
  Self-checking bench for the shift, rotate and single-bit unit.
  Assumes the byte memory model on the memory side.
*/
`timescale 1ns/100ps
module srb_shift_bit_unit_tb;
  import srb_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic reqValid = 1'b0;
  srb_req_s req = '0;
  logic memRdValid;
  logic [7:0] memRdData;
  srb_res_s res;
  logic resValid;
  srb_mem_s mem;
  logic busy;
  logic [3:0] lat = 4'h1;
  int err_total = 0;
  int checked = 0;

  always #5 mclk = ~mclk;

  srb_shift_bit_unit srb_shift_bit_unit_inst (.mclk(mclk), .nrst(nrst), .reqValid(reqValid),
    .req(req), .memRdValid(memRdValid), .memRdData(memRdData), .res(res),
    .resValid(resValid), .mem(mem), .busy(busy));
  srb_mem_model srb_mem_model_inst (.mclk(mclk), .nrst(nrst), .mem(mem), .lat(lat),
    .memRdValid(memRdValid), .memRdData(memRdData));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_op(input srb_req_s r, output srb_res_s g, output logic w,
                       output logic [7:0] d, output logic sb);
    @(negedge mclk);
    req = r;
    reqValid = 1'b1;
    @(negedge mclk);
    reqValid = 1'b0;
    sb = 1'b0;
    for (int n = 0; n < 40; n++) begin
      if (resValid === 1'b1) break;
      sb |= (busy === 1'b1);
      @(negedge mclk);
    end
    g = res;
    w = mem.write;
    d = mem.wdata;
    chk(32'(resValid), 32'h1);
  endtask

  function automatic logic [32:0] shx(srb_op_e op, int w, logic [31:0] v, logic c);
    logic [31:0] m;
    logic [31:0] r;
    logic fill;
    m = (w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
    case (op)
      OP_ROTATE_LEFT, OP_ARITH_SHIFT_RIGHT: fill = v[w-1];
      OP_ROTATE_RIGHT: fill = v[0];
      OP_ROTATE_CARRY_LEFT, OP_ROTATE_CARRY_RIGHT: fill = c;
      default: fill = 1'b0;
    endcase
    if (!op[0]) r = (v << 1) | {31'h0, fill};
    else r = ((v & m) >> 1) | ({31'h0, fill} << (w - 1));
    return {(op[0] ? v[0] : v[w-1]), (r & m) | (v & ~m)};
  endfunction

  function automatic logic [9:0] bitx(srb_op_e op, logic [7:0] b, logic [2:0] n, logic c);
    logic [7:0] r;
    logic cr;
    logic s;
    r = b;
    cr = c;
    s = b[n];
    case (op)
      OP_BIT_SET: r[n] = 1'b1;
      OP_BIT_CLEAR: r[n] = 1'b0;
      OP_BIT_INVERT: r[n] = ~s;
      OP_CARRY_AND: cr = c & s;
      OP_CARRY_AND_INV: cr = c & ~s;
      OP_CARRY_OR: cr = c | s;
      OP_CARRY_OR_INV: cr = c | ~s;
      OP_CARRY_XOR: cr = c ^ s;
      OP_CARRY_XOR_INV: cr = c ^ ~s;
      OP_BIT_LOAD: cr = s;
      OP_BIT_LOAD_INV: cr = ~s;
      OP_BIT_STORE: r[n] = c;
      OP_BIT_STORE_INV: r[n] = ~c;
      default: ;
    endcase
    return {~s, cr, r};
  endfunction

  task automatic t_shift();
    srb_req_s r;
    srb_res_s g;
    logic w;
    logic [7:0] d;
    logic sb;
    logic [32:0] e;
    int ws[3] = '{8, 16, 32};
    logic [31:0] vs[2] = '{32'h8000_8081, 32'h4001_7f02};
    for (int s = 0; s < 3; s++)
      for (int o = 0; o < 8; o++)
        for (int k = 0; k < 2; k++) begin
          r = '0;
          r.op = srb_op_e'(o);
          r.size = srb_size_e'(s);
          r.regVal = vs[k];
          r.carryIn = k[0];
          do_op(r, g, w, d, sb);
          e = shx(r.op, ws[s], vs[k], k[0]);
          chk(g.value, e[31:0]);
          chk(32'({g.carry, g.carryWrite, g.regWrite}), 32'({e[32], 2'b11}));
        end
    $display("test shift done");
  endtask

  task automatic t_bits(input logic memOp);
    srb_req_s r;
    srb_res_s g;
    logic w;
    logic [7:0] d;
    logic sb;
    logic [9:0] e;
    logic fr;
    logic md;
    logic cw;
    for (int o = 8; o < 22; o++)
      for (int n = 0; n < 8; n++)
        for (int c = 0; c < 2; c++) begin
          r = '0;
          r.op = srb_op_e'(o);
          r.regVal = 32'h1234_5600 | 32'(8'ha5 ^ 8'(n * 27));
          fr = (o < 12) && c[0];
          r.bitFromReg = fr;
          r.bitImm = fr ? ~3'(n) : 3'(n);
          r.bitRegLow = fr ? 3'(n) : ~3'(n);
          r.carryIn = c[0];
          r.memOperand = memOp;
          r.memAddr = 32'(n);
          lat = c[0] ? 4'h3 : 4'h1;
          md = (o < 11) || (o > 19);
          cw = (o > 11) && (o < 20);
          e = bitx(r.op, memOp ? srb_mem_model_inst.store[n] : r.regVal[7:0], 3'(n), c[0]);
          do_op(r, g, w, d, sb);
          // Let the write-back land in the model before it is read
          if (memOp) @(negedge mclk);
          chk(32'({g.regWrite, g.zeroWrite, g.carryWrite, g.badRequest}),
              32'({md & ~memOp, o == 11, cw, 1'b0}));
          if (md) chk(32'(g.value[7:0]), 32'(e[7:0]));
          if (o == 11) chk(32'(g.zero), 32'(e[9]));
          if (cw) chk(32'(g.carry), 32'(e[8]));
          if (memOp) begin
            chk(32'({w, sb}), 32'({md, 1'b1}));
            if (md) chk(32'({d, srb_mem_model_inst.store[n]}), 32'({e[7:0], e[7:0]}));
          end
        end
    $display("test bits mem=%0d done", memOp);
  endtask

  task automatic t_badreq();
    srb_req_s r;
    srb_res_s g;
    logic w;
    logic [7:0] d;
    logic sb;
    for (int o = 13; o < 22; o += 2) begin
      r = '0;
      r.op = srb_op_e'(o);
      r.regVal = 32'h0000_00ff;
      r.bitFromReg = 1'b1;
      do_op(r, g, w, d, sb);
      chk(32'({g.badRequest, g.regWrite, g.carryWrite, g.zeroWrite}), 32'h8);
    end
    $display("test refused source done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    $display("ERROR at %0t ns: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    t_shift();
    t_bits(1'b0);
    t_bits(1'b1);
    t_badreq();
    wrap_up();
  end
endmodule // srb_shift_bit_unit_tb
